// ### dv/hall_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module hall_ctrl_chk (
  // Watched ports
  input wire logic       clk_sys_i,
  input wire logic       reset_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       meas_active_o,
  input wire logic       asleep_o,
  input wire logic [2:0] sig_sel_o,
  input wire logic       alert_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Bus steps
  sequence s_scl_high; scl_i ##1 scl_i; endsequence
  sequence s_ack_rise; !scl_i && $rose(sda_oe_o); endsequence
  a_reset_quiet: assert property ($fell(reset_i) |->
    !sda_oe_o && !meas_active_o && !asleep_o) else $error("busy after reset");
  a_reset_pins: assert property ($fell(reset_i) |->
    sig_sel_o == 3'h0 && !alert_o) else $error("pins not preset");
  a_open_drain: assert property (!sda_o)
    else $error("data value not low");
  a_scl_high_hold: assert property (s_scl_high |-> $stable(sda_oe_o))
    else $error("data moved with clock high");
  a_ack_hold: assert property (s_ack_rise |-> sda_oe_o [*8])
    else $error("drive too short");
  a_sleep_idle: assert property (asleep_o |-> !meas_active_o)
    else $error("measuring asleep");
  a_cfg_scl_low: assert property ($changed(sig_sel_o) |-> !scl_i)
    else $error("select moved off byte end");
  a_stop_free: assert property (scl_i && $past(scl_i) && $rose(sda_i) |->
    !sda_oe_o) else $error("driving at stop");
endmodule : hall_ctrl_chk

bind hall_sensor_i2c_control hall_ctrl_chk chk (.clk_sys_i, .reset_i, .scl_i, .sda_i, .sda_o,
  .sda_oe_o, .meas_active_o, .asleep_o, .sig_sel_o, .alert_o);
`default_nettype wire

// ### dv/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  // System
  input  wire logic clk_sys_i,
  // Bus lines
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  localparam int Q = 14; // Quarter bit, bus near 357 kHz
  // Idle bus released
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask : w
  // One bit out, line sampled mid high
  task automatic bit_x(input logic tx, output logic rx);
    sda_oe_o = !tx;
    w(Q);
    scl_o = 1'b1;
    w(Q);
    rx = sda_i;
    w(Q);
    scl_o = 1'b0;
    w(Q);
  endtask : bit_x
  // Start or repeated start, data falls with clock high
  task automatic start();
    sda_oe_o = 1'b0;
    w(Q);
    scl_o = 1'b1;
    w(2 * Q);
    sda_oe_o = 1'b1;
    w(2 * Q);
    scl_o = 1'b0;
    w(Q);
  endtask : start
  task automatic stop();
    sda_oe_o = 1'b1;
    w(Q);
    scl_o = 1'b1;
    w(2 * Q);
    sda_oe_o = 1'b0;
    w(2 * Q);
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    a = !r;
  endtask : wbyte
  // Host answers with acknowledge unless last byte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask : rbyte
endmodule : i2c_host_model
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import hall_pkg::*; ();
  localparam int LIMIT = 80000; // Run ceiling in cycles
  logic clk_sys_i = 1'b0, reset_i = 1'b1, sample_valid_i = 1'b0;
  logic scl, host_oe, sda_o, dut_oe, meas, asleep, alert, ack;
  logic [14:0] smp = 15'h4000;
  logic [2:0] sel;
  logic [15:0] rnd = 16'h0034;
  logic [7:0] rb [2];
  logic [4:0] tick = 5'h00;
  int bad_count = 0, comparisons = 0, cyc = 0;
  wire logic sda = !(host_oe | dut_oe); // Pulled-up wire
  hall_sensor_i2c_control dut (.clk_sys_i, .reset_i, .scl_i(scl), .sda_i(sda), .sda_o,
    .sda_oe_o(dut_oe), .sample_i(smp), .sample_valid_i, .meas_active_o(meas),
    .asleep_o(asleep), .sig_sel_o(sel), .alert_o(alert));
  i2c_host_model host (.clk_sys_i, .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
  always #25 clk_sys_i = !clk_sys_i;
  // Sample strobe every 32 cycles and run ceiling
  always @(posedge clk_sys_i) begin
    #2;
    tick = tick + 5'h01;
    sample_valid_i = (tick == 5'h00);
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      wrap_up();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] msb_exp(input logic [14:0] s);
    return {1'b1, s[14:8]};
  endfunction : msb_exp
  function automatic logic alert_exp(input logic [14:0] s);
    int f, thr;
    f = int'(s[14:2]) - int'(FIELD_ZERO);
    thr = (16 + int'(CFG_PRESET.sw_op[3:0])) << CFG_PRESET.sw_op[6:4];
    return (f >= thr + int'(CFG_PRESET.hyst)) ^ CFG_PRESET.low4;
  endfunction : alert_exp
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic addr(input logic rw);
    host.wbyte({DEV_ADDR_MIN, rw}, ack);
    check("address ack", 8'h01, {7'h00, ack});
  endtask : addr
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.start();
    addr(1'b0);
    host.wbyte(p, ack);
    check("pointer ack", 8'h01, {7'h00, ack});
    host.wbyte(d, ack);
    check("data ack", 8'h01, {7'h00, ack});
    host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] p, input int n);
    host.start();
    addr(1'b0);
    host.wbyte(p, ack);
    host.start();
    addr(1'b1);
    for (int i = 0; i < n; i++) host.rbyte(i == n - 1, rb[i]);
    host.stop();
  endtask : rd
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys_i);
    #2 reset_i = 1'b0;
    host.start();
    addr(1'b1);
    host.rbyte(1'b1, rb[0]);
    host.stop();
    check("wake data", WAKE_DATA, rb[0]);
    host.w(220);
    rd(REG_CTRL, 1);
    check("stop after wake", 8'h02, rb[0] & 8'h02);
    for (int i = 1; i < 4; i++) begin
      host.start();
      host.wbyte({DEV_ADDR_MIN + 7'(i), 1'b0}, ack);
      host.stop();
      check("foreign ack", 8'h00, {7'h00, ack});
    end
    repeat (4) begin
      rnd = lfsr(rnd);
      wr(REG_SIGSEL, {5'h00, rnd[2:0]});
      check("select pin", {5'h00, rnd[2:0]}, {5'h00, sel});
      rd(REG_SIGSEL, 1);
      check("select read", {5'h00, rnd[2:0]}, rb[0]);
    end
    rnd = lfsr(rnd);
    smp = rnd[14:0];
    wr(REG_AUTOINC, 8'h01);
    wr(REG_CTRL, 8'h04);
    rd(REG_CTRL, 1);
    check("burst done", 8'h02, rb[0] & 8'h06);
    rd(REG_MSB, 2);
    check("result high", msb_exp(smp), rb[0]);
    check("result low", smp[7:0], rb[1]);
    check("alert level", {7'h00, alert_exp(smp)}, {7'h00, alert});
    wr(REG_SWOP, 8'h15);
    wr(REG_CTRL, 8'h09);
    for (int i = 0; i < 200 && asleep !== 1'b1; i++) host.w(1);
    check("sleep state", 8'h02, {6'h00, asleep, meas});
    host.w(20000);
    check("timerless sleep", 8'h02, {6'h00, asleep, meas});
    host.start();
    addr(1'b0);
    host.wbyte(REG_SWOP, ack);
    host.stop();
    check("pointer after wake", 8'h00, {7'h00, ack});
    host.w(220);
    rd(REG_AUTOINC, 1);
    check("autoinc lost", 8'h00, rb[0] & 8'h01);
    rd(REG_CTRL, 1);
    check("idle after wake", 8'h02, rb[0] & 8'h03);
    rd(REG_SWOP, 1);
    check("trip point kept", 8'h15, rb[0]);
    check("select reloaded", 8'h00, {5'h00, sel});
    wrap_up();
  end
endmodule : tb
`default_nettype wire

// ### rtl/alert_compare.sv
`timescale 1ns/1ps
`default_nettype none
module alert_compare import hall_pkg::*; (
  // System
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // Field and settings
  input  wire logic [14:0] result_i,
  input  wire logic [6:0]  sw_op_i,
  input  wire logic [5:0]  hyst_i,
  input  wire logic        low4_i,
  input  wire logic [1:0]  polsel_i,
  input  wire logic [5:0]  tamper_i,
  // Output pin level
  output logic             alert_o
);
  logic signed [14:0] f, thr, op_pt, rel_pt, tam;
  logic strong_reg, strong_next;

  // Decision point from the coded setting
  function automatic logic signed [14:0] thresh(input logic [6:0] op);
    thresh = (op == SW_OP_LATCH) ? '0 : 15'({1'b1, op[3:0]}) << op[6:4];
  endfunction : thresh

  // Hysteresis switch with tamper override
  always_comb begin
    f = $signed({2'h0, result_i[14:2]}) - FIELD_ZERO;
    if (polsel_i[1]) f = -f;
    if (polsel_i[0] && f < 0) f = -f; // RULE19
    thr = thresh(sw_op_i);
    op_pt = thr + $signed({9'h0, hyst_i});
    rel_pt = thr - $signed({9'h0, hyst_i});
    tam = $signed({9'h0, tamper_i}) <<< TAMPER_SHIFT;
    strong_next = strong_reg;
    if (f >= op_pt) strong_next = 1'b1; // RULE18
    else if (f < rel_pt) strong_next = 1'b0; // RULE18
    if (tamper_i != TAMPER_OFF && (f > tam || -f > tam)) strong_next = 1'b0; // RULE20
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) strong_reg <= 1'b0;
    else strong_reg <= strong_next;
  end

  assign alert_o = low4_i ? ~strong_reg : strong_reg; // RULE18
endmodule : alert_compare
`default_nettype wire

// ### rtl/field_filter.sv
`timescale 1ns/1ps
`default_nettype none
module field_filter import hall_pkg::*; #(
  parameter int SW = SAMPLE_W,
  parameter int ML = MAX_LOG2
) (
  // System
  input  wire logic          clk_sys_i,
  input  wire logic          reset_i,
  // Control
  input  wire logic          start_i,
  input  wire logic          iir_i,
  input  wire logic [3:0]    log2_i,
  // Samples
  input  wire logic          valid_i,
  input  wire logic [SW-1:0] sample_i,
  // Result
  output logic               done_o,
  output logic [SW-1:0]      result_o
);
  logic [SW+ML-1:0] acc_reg, acc_next, sum;
  logic [ML:0]      cnt_reg, cnt_next;
  logic [SW-1:0]    res_reg, res_next;
  logic             done_reg, done_next;
  logic [3:0]       n;

  // Average a burst or run a leaky accumulator
  always_comb begin
    n = (log2_i > 4'(ML)) ? 4'(ML) : log2_i;
    acc_next = acc_reg;
    cnt_next = cnt_reg;
    res_next = res_reg;
    done_next = 1'b0;
    sum = acc_reg + (SW+ML)'(sample_i);
    if (start_i && !iir_i) begin
      acc_next = '0;
      cnt_next = '0;
    end else if (valid_i && iir_i) begin
      acc_next = sum - (acc_reg >> n); // RULE21
      res_next = SW'(acc_next >> n);
      done_next = 1'b1;
    end else if (valid_i) begin
      if (cnt_reg == (ML+1)'((1 << n) - 1)) begin // RULE21
        res_next = SW'(sum >> n);
        done_next = 1'b1;
        acc_next = '0;
        cnt_next = '0;
      end else begin
        acc_next = sum;
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      acc_reg <= '0;
      cnt_reg <= '0;
      res_reg <= SW'(FIELD_ZERO <<< 2);
      done_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      cnt_reg <= cnt_next;
      res_reg <= res_next;
      done_reg <= done_next;
    end
  end

  assign done_o = done_reg;
  assign result_o = res_reg;
endmodule : field_filter
`default_nettype wire

// ### rtl/hall_pkg.sv
package hall_pkg;
  // System clock and timer ticks
  localparam int SYS_CLK_MHZ   = 20;
  localparam int SLEEP_TICK_NS = 100000;
  localparam int FAST_TICK_NS  = 1000;
  localparam int SLEEP_TICK_CYC = (SLEEP_TICK_NS * SYS_CLK_MHZ) / 1000;
  localparam int FAST_TICK_CYC  = (FAST_TICK_NS * SYS_CLK_MHZ) / 1000;
  localparam int TICK_W = 12;

  // Bus addressing
  localparam logic [6:0] DEV_ADDR_MIN = 7'h30;
  localparam logic [6:0] DEV_ADDR_MAX = 7'h33;
  localparam logic       DIR_READ     = 1'h1;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [7:0] WAKE_DATA    = 8'hFF;

  // Register pointers
  localparam logic [7:0] REG_ID     = 8'hC0;
  localparam logic [7:0] REG_MSB    = 8'hC1;
  localparam logic [7:0] REG_LSB    = 8'hC2;
  localparam logic [7:0] REG_SIGSEL = 8'hC3;
  localparam logic [7:0] REG_CTRL   = 8'hC4;
  localparam logic [7:0] REG_AUTOINC = 8'hC5;
  localparam logic [7:0] REG_SWOP   = 8'hC6;
  localparam logic [7:0] REG_SWHYST = 8'hC7;
  localparam logic [7:0] REG_SLTIME = 8'hC8;
  localparam logic [7:0] REG_TAMPER = 8'hC9;
  localparam logic [7:0] REG_FILT   = 8'hCD;

  // Control and auto-increment register bit positions
  localparam int MEAS_BIT     = 7;
  localparam int USESTORE_BIT = 3;
  localparam int ONEBURST_BIT = 2;
  localparam int STOP_BIT     = 1;
  localparam int SLEEP_BIT    = 0;
  localparam int AUTOINC_BIT  = 0;

  // Field and filter constants
  localparam int SAMPLE_W = 15;
  localparam int MAX_LOG2 = 12;
  localparam logic [6:0]  SW_OP_LATCH  = 7'h7F;
  localparam logic [5:0]  TAMPER_OFF   = 6'h3F;
  localparam int          TAMPER_SHIFT = 6;
  localparam logic signed [14:0] FIELD_ZERO = 15'sh1000;

  // Software visible configuration
  typedef struct packed {
    logic       usestore;
    logic       oneburst;
    logic       stop;
    logic       sleep;
    logic       autoinc;
    logic [2:0] sig_sel;
    logic       low4;
    logic [6:0] sw_op;
    logic [1:0] polsel;
    logic [5:0] hyst;
    logic [7:0] sltime;
    logic [5:0] tamper;
    logic       slfast;
    logic       sltimeena;
    logic [3:0] burst;
    logic [2:0] bw;
    logic       iir;
  } cfg_t;

  localparam cfg_t CFG_PRESET = '{usestore: 1'h0, oneburst: 1'h0, stop: 1'h0,
    sleep: 1'h0, autoinc: 1'h0, sig_sel: 3'h0, low4: 1'h0, sw_op: 7'h4C,
    polsel: 2'h0, hyst: 6'h1C, sltime: 8'h08, tamper: 6'h3F, slfast: 1'h0,
    sltimeena: 1'h1, burst: 4'h0, bw: 3'h0, iir: 1'h0};

  // One-cycle events from the bus side
  typedef struct packed {
    logic       wr;
    logic       rd_msb;
    logic       wake;
    logic [7:0] addr;
    logic [7:0] data;
  } bus_evt_t;

  typedef enum logic [4:0] {
    I_IDLE = 5'h01, I_RX = 5'h02, I_RACK = 5'h04, I_TX = 5'h08, I_TACK = 5'h10
  } i2c_st_t;

  typedef enum logic [2:0] {
    P_IDLE = 3'h1, P_MEAS = 3'h2, P_SLEEP = 3'h4
  } pwr_st_t;
endpackage : hall_pkg

// ### rtl/hall_sensor_i2c_control.sv
// How it works
// RULE1: Answer only the one 7-bit address chosen at build, 0x30 to 0x33.
// RULE2: Fast mode, 7-bit addressing; host clocks at most 400 kHz.
// RULE3: Write is address, pointer, data; each of the three bytes acked.
// RULE4: Read sets pointer, repeated start, read address, one byte, host NACK.
// RULE5: Direction bit 0 means write, 1 means read.
// RULE6: Auto-increment bit advances pointer per byte; host ACK continues a read.
// RULE7: Address-only read wakes or interrupts loop; data returned is 0xFF.
// RULE8: After an address-only write wake, a following pointer byte is NACKed.
// RULE9: Host waits 10 us after wake acknowledge before next start.
// RULE10: Any wake leaves the part idle with the stop bit set; only a wake from sleep forces idle, a wake in P_MEAS keeps measuring.
// RULE11: Single burst with stop cleared measures once, then stop returns to 1.
// RULE12: Clearing stop with sleep clear resumes the timed measure cycle.
// RULE13: Sleep 1 with stop 0 sleeps with no timer, no measurements.
// RULE14: Host waits 500 us after timer re-enable before sleeping again.
// RULE15: Host should stop measurements before changing measurement settings.
// RULE16: Retain bit keeps pin trip points through sleep; rest reloads.
// RULE17: Power-up loads preset configuration and starts in preset mode.
// RULE18: Alert switches at operate and release points, direction selectable.
// RULE19: Optional magnitude compare makes alert independent of polarity.
// RULE20: Field above tamper level forces alert to its zero-field level.
// RULE21: Filter averages a burst or accumulates, over 1 to 4096 samples.
// RULE22: Result is a 15-bit unsigned code, zero field at mid-scale.
// RULE23: Single-burst bit clears itself when the conversion starts.
// RULE24: Auto-increment enable is lost in sleep and reads cleared after wake.
// RULE25: Pointer written in a write stays valid for a read after restart.
`timescale 1ns/1ps
`default_nettype none
module hall_sensor_i2c_control import hall_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_MIN,
  parameter cfg_t       PRESET   = CFG_PRESET,
  parameter logic [3:0] CHIP_ID  = 4'h5, // Arbitrary value
  parameter logic [3:0] REV_ID   = 4'h2  // Arbitrary value
) (
  // System
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // Two-wire bus
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Sensor front end
  input  wire logic [14:0] sample_i,
  input  wire logic        sample_valid_i,
  output logic             meas_active_o,
  output logic             asleep_o,
  output logic [2:0]       sig_sel_o,
  // Output pin
  output logic             alert_o
);
  i2c_st_t    ist_reg, ist_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next, tx_reg, tx_next, ptr_reg, ptr_next;
  logic       rd_reg, rd_next, first_reg, first_next, ptrph_reg, ptrph_next;
  logic       wakex_reg, wakex_next, oe_reg, oe_next, ack_reg, ack_next;
  logic       scl_q_reg, sda_q_reg;
  logic       scl_rise, scl_fall, start_det, stop_det;
  bus_evt_t   evt;

  pwr_st_t     pst_reg, pst_next;
  cfg_t        cfg_reg, cfg_next;
  logic [TICK_W-1:0] tick_reg, tick_next, tick_len;
  logic [7:0]  tmr_reg, tmr_next;
  logic        single_reg, single_next, fresh_reg, fresh_next;
  logic [14:0] res_reg, res_next, f_res;
  logic [7:0]  lsb_reg, lsb_next;
  logic        f_start, f_done, tmr_done;

  // Byte returned for a register pointer
  function automatic logic [7:0] rd_byte(input logic [7:0] a, input cfg_t c,
      input logic meas, input logic fresh, input logic [14:0] r,
      input logic [7:0] lsb);
    rd_byte = '0;
    case (a)
      REG_ID:     rd_byte = {CHIP_ID, REV_ID};
      REG_MSB:    rd_byte = {fresh, r[14:8]};
      REG_LSB:    rd_byte = lsb;
      REG_SIGSEL: rd_byte = {5'h0, c.sig_sel};
      REG_CTRL: begin
        rd_byte[MEAS_BIT] = meas;
        rd_byte[USESTORE_BIT] = c.usestore;
        rd_byte[ONEBURST_BIT] = c.oneburst;
        rd_byte[STOP_BIT] = c.stop;
        rd_byte[SLEEP_BIT] = c.sleep;
      end
      REG_AUTOINC: rd_byte[AUTOINC_BIT] = c.autoinc;
      REG_SWOP:   rd_byte = {c.low4, c.sw_op};
      REG_SWHYST: rd_byte = {c.polsel, c.hyst};
      REG_SLTIME: rd_byte = c.sltime;
      REG_TAMPER: rd_byte = {c.tamper, c.slfast, c.sltimeena};
      REG_FILT:   rd_byte = {c.burst, c.bw, c.iir};
      default:    rd_byte = '0;
    endcase
  endfunction : rd_byte

  // Store a written byte into its fields
  function automatic cfg_t wr_cfg(input cfg_t c, input logic [7:0] a,
      input logic [7:0] d);
    wr_cfg = c;
    case (a)
      REG_SIGSEL: wr_cfg.sig_sel = d[2:0];
      REG_CTRL: begin
        wr_cfg.usestore = d[USESTORE_BIT];
        wr_cfg.oneburst = d[ONEBURST_BIT];
        wr_cfg.stop = d[STOP_BIT];
        wr_cfg.sleep = d[SLEEP_BIT];
      end
      REG_AUTOINC: wr_cfg.autoinc = d[AUTOINC_BIT];
      REG_SWOP:   {wr_cfg.low4, wr_cfg.sw_op} = d;
      REG_SWHYST: {wr_cfg.polsel, wr_cfg.hyst} = d;
      REG_SLTIME: wr_cfg.sltime = d;
      REG_TAMPER: {wr_cfg.tamper, wr_cfg.slfast, wr_cfg.sltimeena} = d;
      REG_FILT:   {wr_cfg.burst, wr_cfg.bw, wr_cfg.iir} = d;
      default:    wr_cfg = c;
    endcase
  endfunction : wr_cfg

  // Settings after leaving sleep
  function automatic cfg_t reload(input cfg_t c, input cfg_t p);
    reload = p;
    reload.usestore = c.usestore;
    reload.autoinc = 1'b0; // RULE24
    if (c.usestore) begin // RULE16
      reload.low4 = c.low4;
      reload.sw_op = c.sw_op;
      reload.polsel = c.polsel;
      reload.hyst = c.hyst;
    end
  endfunction : reload

  // Bus line edges, sampled on the system clock
  assign scl_rise = scl_i & ~scl_q_reg; // RULE2
  assign scl_fall = ~scl_i & scl_q_reg;
  assign start_det = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
  assign stop_det = scl_i & scl_q_reg & ~sda_q_reg & sda_i;

  // Target byte engine
  always_comb begin
    ist_next = ist_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    rd_next = rd_reg;
    first_next = first_reg;
    ptrph_next = ptrph_reg;
    wakex_next = wakex_reg;
    oe_next = oe_reg;
    ack_next = ack_reg;
    evt = '0;
    if (start_det) begin
      ist_next = I_RX;
      cnt_next = '0;
      first_next = 1'b1;
      oe_next = 1'b0;
    end else if (stop_det) begin
      ist_next = I_IDLE;
      oe_next = 1'b0;
      wakex_next = 1'b0;
    end else begin
      case (ist_reg)
        I_RX: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_i};
            cnt_next = cnt_reg + 1'b1;
          end else if (scl_fall && cnt_reg == BYTE_BITS) begin
            cnt_next = '0;
            ist_next = I_RACK;
            oe_next = 1'b1;
            if (first_reg) begin
              first_next = 1'b0;
              rd_next = (sh_reg[0] == DIR_READ); // RULE5
              ptrph_next = (sh_reg[0] != DIR_READ);
              if (sh_reg[7:1] != DEV_ADDR) begin // RULE1
                ist_next = I_IDLE;
                oe_next = 1'b0;
              end else begin
                evt.wake = (pst_reg == P_SLEEP) | ~cfg_reg.stop; // RULE7
                wakex_next = evt.wake;
              end
            end else if (ptrph_reg) begin
              ptrph_next = 1'b0;
              if (wakex_reg) begin // RULE8
                ist_next = I_IDLE;
                oe_next = 1'b0;
              end else begin
                ptr_next = sh_reg; // RULE25
              end
            end else begin
              evt.wr = 1'b1; // RULE3
              evt.addr = ptr_reg;
              evt.data = sh_reg;
              if (cfg_reg.autoinc) ptr_next = ptr_reg + 1'b1; // RULE6
            end
          end
        end
        I_RACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            ist_next = I_RX;
            if (rd_reg) begin // RULE4
              ist_next = I_TX;
              tx_next = wakex_reg ? WAKE_DATA // RULE7
                : rd_byte(ptr_reg, cfg_reg, pst_reg == P_MEAS, fresh_reg,
                          res_reg, lsb_reg);
              evt.rd_msb = ~wakex_reg & (ptr_reg == REG_MSB);
              oe_next = ~tx_next[7];
            end
          end
        end
        I_TX: begin
          if (scl_fall) begin
            if (cnt_reg == BYTE_BITS - 1'b1) begin
              ist_next = I_TACK;
              oe_next = 1'b0;
              if (cfg_reg.autoinc) ptr_next = ptr_reg + 1'b1; // RULE6
            end else begin
              tx_next = {tx_reg[6:0], 1'b1};
              oe_next = ~tx_reg[6];
              cnt_next = cnt_reg + 1'b1;
            end
          end
        end
        I_TACK: begin
          if (scl_rise) begin
            ack_next = ~sda_i;
          end else if (scl_fall) begin
            cnt_next = '0;
            ist_next = I_IDLE; // RULE4
            if (ack_reg) begin // RULE6
              ist_next = I_TX;
              tx_next = wakex_reg ? WAKE_DATA
                : rd_byte(ptr_reg, cfg_reg, pst_reg == P_MEAS, fresh_reg,
                          res_reg, lsb_reg);
              evt.rd_msb = ~wakex_reg & (ptr_reg == REG_MSB);
              oe_next = ~tx_next[7];
            end
          end
        end
        default: ist_next = I_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ist_reg <= I_IDLE;
      cnt_reg <= '0;
      sh_reg <= '0;
      tx_reg <= '0;
      ptr_reg <= '0;
      rd_reg <= 1'b0;
      first_reg <= 1'b0;
      ptrph_reg <= 1'b0;
      wakex_reg <= 1'b0;
      oe_reg <= 1'b0;
      ack_reg <= 1'b0;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      ist_reg <= ist_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      rd_reg <= rd_next;
      first_reg <= first_next;
      ptrph_reg <= ptrph_next;
      wakex_reg <= wakex_next;
      oe_reg <= oe_next;
      ack_reg <= ack_next;
      scl_q_reg <= scl_i;
      sda_q_reg <= sda_i;
    end
  end

  // Sleep and idle interval timer
  assign tick_len = cfg_reg.slfast ? TICK_W'(FAST_TICK_CYC - 1)
                                   : TICK_W'(SLEEP_TICK_CYC - 1);
  assign tmr_done = (tick_reg == tick_len) && (tmr_reg == cfg_reg.sltime);

  // Power and measurement sequencer
  always_comb begin
    cfg_next = cfg_reg;
    pst_next = pst_reg;
    single_next = single_reg;
    fresh_next = fresh_reg;
    res_next = res_reg;
    lsb_next = lsb_reg;
    f_start = 1'b0;
    if (evt.wr) cfg_next = wr_cfg(cfg_reg, evt.addr, evt.data);
    if (evt.rd_msb) begin
      lsb_next = res_reg[7:0];
      fresh_next = 1'b0;
    end
    case (pst_reg)
      P_IDLE: begin
        if (cfg_next.oneburst) begin
          cfg_next.oneburst = 1'b0; // RULE23
          single_next = 1'b1; // RULE11
          pst_next = P_MEAS;
          f_start = 1'b1;
        end else if (!cfg_next.stop && cfg_next.sleep) begin
          pst_next = P_SLEEP; // RULE13
        end else if (!cfg_next.stop && tmr_done) begin
          pst_next = P_MEAS; // RULE12
          f_start = 1'b1;
        end
      end
      P_MEAS: begin
        if (f_done) begin
          res_next = f_res; // RULE22
          fresh_next = 1'b1;
          pst_next = P_IDLE;
          if (single_reg) begin
            cfg_next.stop = 1'b1; // RULE11
            single_next = 1'b0;
          end else if (!cfg_next.stop && (cfg_next.sleep || cfg_next.sltimeena)) begin
            pst_next = P_SLEEP; // RULE12
          end
        end
      end
      P_SLEEP: begin
        if (!cfg_reg.sleep && tmr_done) begin // RULE13
          cfg_next = reload(cfg_reg, PRESET); // RULE16
          pst_next = P_MEAS;
          f_start = 1'b1;
        end
      end
      default: pst_next = P_IDLE;
    endcase
    if (evt.wake) begin
      if (pst_reg == P_SLEEP) begin
        cfg_next = reload(cfg_reg, PRESET); // RULE24
        pst_next = P_IDLE; // RULE10
      end
      cfg_next.stop = 1'b1; // RULE10
      cfg_next.sleep = 1'b0;
    end
    tick_next = (tick_reg == tick_len) ? '0 : tick_reg + 1'b1;
    tmr_next = (tick_reg == tick_len) ? tmr_reg + 1'b1 : tmr_reg;
    if (pst_next != pst_reg || tmr_done || pst_reg == P_MEAS) begin
      tick_next = '0;
      tmr_next = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pst_reg <= P_IDLE; // RULE17
      cfg_reg <= PRESET; // RULE17
      tick_reg <= '0;
      tmr_reg <= '0;
      single_reg <= 1'b0;
      fresh_reg <= 1'b0;
      res_reg <= 15'(FIELD_ZERO <<< 2);
      lsb_reg <= '0;
    end else begin
      pst_reg <= pst_next;
      cfg_reg <= cfg_next;
      tick_reg <= tick_next;
      tmr_reg <= tmr_next;
      single_reg <= single_next;
      fresh_reg <= fresh_next;
      res_reg <= res_next;
      lsb_reg <= lsb_next;
    end
  end

  // Filter fed only while measuring
  field_filter u_filter (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .start_i   (f_start),
    .iir_i     (cfg_reg.iir),
    .log2_i    (cfg_reg.burst),
    .valid_i   (sample_valid_i && pst_reg == P_MEAS),
    .sample_i  (sample_i),
    .done_o    (f_done),
    .result_o  (f_res)
  );

  // Output pin decision
  alert_compare u_alert (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .result_i  (res_reg),
    .sw_op_i   (cfg_reg.sw_op),
    .hyst_i    (cfg_reg.hyst),
    .low4_i    (cfg_reg.low4),
    .polsel_i  (cfg_reg.polsel),
    .tamper_i  (cfg_reg.tamper),
    .alert_o   (alert_o)
  );

  // Status outputs
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_reg;
  assign meas_active_o = (pst_reg == P_MEAS);
  assign asleep_o = (pst_reg == P_SLEEP);
  assign sig_sel_o = cfg_reg.sig_sel;
endmodule : hall_sensor_i2c_control
`default_nettype wire
